// ===== sba_arbiter.sv
/*
 * System bus arbiter for eight masters: fixed priority with optional core
 * boost, or rotate priority with the external master always first.
 * Assumes every request is synchronous to ref_clk, held until granted and
 * dropped to release the bus; irq_pending is the core's unmasked interrupt.
 */
`timescale 1ns/100ps
`default_nettype none

`include "sba_defines.svh"

// Function
// - At most one master holds the grant, and contending requests are resolved to one winner.
// - While a master holds the bus no other request is granted, whatever its priority.
// - A scheme select of 0, the reset value, picks fixed priority arbitration.
// - In fixed priority the highest-priority requester wins.
// - Without boost the order is external, translator, dma 0, dma 1, mac 0, mac 1, usb, core.
// - With boost enabled and active the core moves to second, right after the external master.
// - With boost disabled the core stays lowest whatever the interrupts do.
// - With boost enabled, the flag clear and no unmasked interrupt, the core stays lowest and the flag stays 0.
// - With boost enabled an unmasked interrupt sets the boost-active flag and lifts the core.
// - The boost-active flag is readable; a clear pulse (a write of 0) clears it unless an interrupt is pending, which sets it.
// - A scheme select of 1 picks rotate priority arbitration.
// - In rotate mode boost is ignored, the external master is first and the rest rotate.
module sba_arbiter
	import sba_pkg::*;
(
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic [`SBA_NUM_MASTERS-1:0] bus_req,
	input  wire logic                        priority_scheme_select,
	input  wire logic                        core_boost_enable,
	input  wire logic                        irq_pending,
	input  wire logic                        core_boost_active_clr,
	output logic      [`SBA_NUM_MASTERS-1:0] bus_grant,
	output logic      [`SBA_IDX_W-1:0]       bus_owner,
	output logic                             bus_busy,
	output logic                             core_boost_active
);

	sba_regs_t                   state_reg;
	sba_regs_t                   state_next;
	logic                        rotate;
	logic                        boost_eff;
	logic                        any_req;
	logic [`SBA_IDX_W-1:0]       winner;

	// Fixed order: external first, core second when boosted, otherwise lowest index wins.
	function automatic logic [`SBA_IDX_W-1:0] pick_fixed(
		input logic [`SBA_NUM_MASTERS-1:0] req,
		input logic                        boost
	);
		logic [`SBA_IDX_W-1:0] sel;
		sel = `SBA_IDX_CORE;
		for (int i = `SBA_NUM_MASTERS - 1; i >= 0; i--) begin
			if (req[i]) begin
				sel = i[`SBA_IDX_W-1:0];
			end
		end
		if (boost && req[`SBA_IDX_CORE] && !req[`SBA_IDX_EXT_MASTER]) begin
			sel = `SBA_IDX_CORE;
		end
		return sel;
	endfunction

	// Rotating order over masters 1..7, starting just after the last one served.
	function automatic logic [`SBA_IDX_W-1:0] pick_rotate(
		input logic [`SBA_NUM_MASTERS-1:0] req,
		input logic [`SBA_IDX_W-1:0]       last
	);
		logic [`SBA_IDX_W-1:0] sel;
		logic                  found;
		logic [`SBA_IDX_W-1:0] cand;
		sel = `SBA_IDX_EXT_MASTER;
		found = 1'b0;
		cand = last;
		for (int k = 1; k < `SBA_NUM_MASTERS; k++) begin
			cand = (cand == `SBA_IDX_CORE) ? `SBA_IDX_ADDR_XLATE : cand + 3'h1;
			if (!found && req[cand]) begin
				sel = cand;
				found = 1'b1;
			end
		end
		if (req[`SBA_IDX_EXT_MASTER]) begin
			sel = `SBA_IDX_EXT_MASTER;
		end
		return sel;
	endfunction

	// Mode decode; boost only counts in fixed mode with the enable set.
	assign rotate    = (priority_scheme_select == `SBA_SCHEME_ROTATE);
	assign boost_eff = !rotate && core_boost_enable && state_reg.boost_active;
	assign any_req   = |bus_req;
	assign winner    = rotate ? pick_rotate(bus_req, state_reg.rr_ptr)
	                          : pick_fixed(bus_req, boost_eff);

	// Next-state logic for grant, owner, rotation pointer and boost flag.
	always_comb begin
		state_next = state_reg;
		case (state_reg.state)
			SBA_IDLE: begin
				if (any_req) begin
					state_next.state = SBA_BUSY;
					state_next.owner = winner;
					state_next.grant = '0;
					state_next.grant[winner] = 1'b1;
					if (rotate && winner != `SBA_IDX_EXT_MASTER) begin
						state_next.rr_ptr = winner;
					end
				end
			end
			SBA_BUSY: begin
				// Other requests wait; the release cycle itself grants nothing.
				if (!bus_req[state_reg.owner]) begin
					state_next.state = SBA_IDLE;
					state_next.grant = `SBA_RST_GRANT;
				end
			end
			default: begin
				state_next.state = SBA_IDLE;
				state_next.grant = `SBA_RST_GRANT;
			end
		endcase
		// Interrupt set wins over a same-cycle software clear so no boost request is lost.
		if (rotate || !core_boost_enable) begin
			state_next.boost_active = 1'b0;
		end else if (irq_pending) begin
			state_next.boost_active = 1'b1;
		end else if (core_boost_active_clr) begin
			state_next.boost_active = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.state        <= SBA_IDLE;
			state_reg.grant        <= `SBA_RST_GRANT;
			state_reg.owner        <= `SBA_RST_OWNER;
			state_reg.rr_ptr       <= `SBA_RST_RR_PTR;
			state_reg.boost_active <= `SBA_RST_BOOST_ACT;
		end else begin
			state_reg <= state_next;
		end
	end

	// All outputs come straight from flip-flops.
	assign bus_grant         = state_reg.grant;
	assign bus_owner         = state_reg.owner;
	assign bus_busy          = (state_reg.state == SBA_BUSY);
	assign core_boost_active = state_reg.boost_active;

	// Checks on the registered behaviour.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Grants are only decided from idle, so every ordering check starts there.
	// The flag checks watch every edge, since the flag moves in any state.
	logic idle_fix;
	logic idle_rot;
	assign idle_fix = !bus_busy && !rotate;
	assign idle_rot = !bus_busy && rotate;

	chk_grant_onehot: assert property (
		$onehot0(bus_grant) && (bus_busy == (bus_grant != '0)))
		else $error("grant not one-hot or busy mismatch");
	chk_owner_holds: assert property (
		bus_busy && bus_req[bus_owner] |=> bus_busy && $stable(bus_grant))
		else $error("grant moved while owner still requests");
	chk_release_gap: assert property (
		bus_busy && !bus_req[bus_owner] |=> bus_grant == '0 ##1 (bus_grant != '0) == $past(any_req))
		else $error("release did not leave one idle cycle");
	chk_fixed_ext_first: assert property (
		idle_fix && bus_req[`SBA_IDX_EXT_MASTER] |=> bus_grant[`SBA_IDX_EXT_MASTER])
		else $error("external master lost in fixed mode");
	chk_fixed_plain: assert property (
		idle_fix && !boost_eff && bus_req[`SBA_IDX_ADDR_XLATE] && !bus_req[`SBA_IDX_EXT_MASTER]
		|=> bus_owner == `SBA_IDX_ADDR_XLATE)
		else $error("translator not second without boost");
	chk_boost_second: assert property (
		idle_fix && core_boost_enable && core_boost_active && bus_req[`SBA_IDX_CORE]
		&& !bus_req[`SBA_IDX_EXT_MASTER] |=> bus_owner == `SBA_IDX_CORE && bus_busy)
		else $error("boosted core not granted second");
	chk_core_lowest: assert property (
		idle_fix && !core_boost_enable && bus_req[`SBA_IDX_CORE]
		&& (bus_req[`SBA_IDX_USB_HOST:0] != '0) |=> !bus_grant[`SBA_IDX_CORE])
		else $error("core won while boost disabled");
	chk_boost_off_zero: assert property (
		!core_boost_enable |=> !core_boost_active)
		else $error("boost flag set with enable low");
	chk_boost_quiet: assert property (
		!rotate && core_boost_enable && !irq_pending && !core_boost_active |=> !core_boost_active)
		else $error("boost flag set without an interrupt");
	chk_boost_set: assert property (
		!rotate && core_boost_enable && irq_pending |=> core_boost_active)
		else $error("boost flag missed an interrupt");
	chk_boost_clear: assert property (
		core_boost_active && core_boost_active_clr && !irq_pending |=> !core_boost_active)
		else $error("boost flag clear ignored");
	chk_rotate_ext: assert property (
		idle_rot && bus_req[`SBA_IDX_EXT_MASTER] |=> bus_grant[`SBA_IDX_EXT_MASTER])
		else $error("external master lost in rotate mode");
	chk_rotate_start: assert property (
		idle_rot && !bus_req[`SBA_IDX_EXT_MASTER] && bus_req[`SBA_IDX_ADDR_XLATE]
		&& state_reg.rr_ptr == `SBA_IDX_CORE |=> bus_owner == `SBA_IDX_ADDR_XLATE)
		else $error("rotation did not start after the core");
	chk_rotate_adv: assert property (
		idle_rot && !bus_req[`SBA_IDX_EXT_MASTER] && bus_req[state_reg.rr_ptr]
		&& ((bus_req >> 1) & ~(8'h01 << (state_reg.rr_ptr - 3'h1))) != '0
		|=> bus_owner != $past(state_reg.rr_ptr))
		else $error("last served master won again");

	cov_fixed_contend: cover property (idle_fix && $countones(bus_req) > 1 ##1 bus_busy);
	cov_boosted_core:  cover property (boost_eff ##1 bus_grant[`SBA_IDX_CORE]);
	cov_rotate_wrap:   cover property (idle_rot && state_reg.rr_ptr == `SBA_IDX_CORE ##1 bus_busy);
	cov_set_vs_clear:  cover property (irq_pending && core_boost_active_clr && core_boost_enable);

endmodule

`default_nettype wire

// ===== sba_defines.svh
/*
 * Constants of the system bus arbiter: master indices, widths and reset values.
 * Assumes inclusion by the arbiter package and the arbiter module only.
 */
`ifndef SBA_DEFINES_SVH
`define SBA_DEFINES_SVH

`define SBA_NUM_MASTERS     8
`define SBA_IDX_W           3
`define SBA_IDX_EXT_MASTER  3'h0
`define SBA_IDX_ADDR_XLATE  3'h1
`define SBA_IDX_DMA_0_A     3'h2
`define SBA_IDX_DMA_1_B     3'h3
`define SBA_IDX_MAC_DMA_0   3'h4
`define SBA_IDX_MAC_DMA_1   3'h5
`define SBA_IDX_USB_HOST    3'h6
`define SBA_IDX_CORE        3'h7
`define SBA_RST_GRANT       8'h00
`define SBA_RST_OWNER       3'h0
`define SBA_RST_RR_PTR      3'h7
`define SBA_RST_BOOST_ACT   1'b0
`define SBA_SCHEME_FIXED    1'b0
`define SBA_SCHEME_ROTATE   1'b1

`endif

// ===== sba_masters.sv
/*
 * Behavioural model of the eight bus masters that face the arbiter.
 * Assumes want pulses for one cycle and bus_grant comes from the arbiter.
 */
`timescale 1ns/100ps
`default_nettype none
module sba_masters (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] want,
	input  wire logic [3:0] hold,
	input  wire logic [7:0] bus_grant,
	output var  logic [7:0] bus_req
);
	logic [3:0] cnt;

	// A master keeps its request until granted, uses the bus for hold+1 granted cycles and
	// then drops the request, which is the only way it can release the bus.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_req <= 8'h00;
			cnt     <= 4'h0;
		end else if ((bus_grant & bus_req) != 8'h00) begin
			cnt     <= cnt + 4'h1;
			bus_req <= ((cnt == hold) ? (bus_req & ~bus_grant) : bus_req) | want;
		end else begin
			cnt     <= 4'h0;
			bus_req <= bus_req | want;
		end
	end
endmodule
`default_nettype wire

// ===== sba_pkg.sv
/*
 * Types of the system bus arbiter: the arbitration state and the state record.
 * Assumes sba_defines.svh is on the include path.
 */
`default_nettype none

`include "sba_defines.svh"

package sba_pkg;

	typedef enum logic [0:0] {
		SBA_IDLE = 1'b0,
		SBA_BUSY = 1'b1
	} sba_state_t;

	typedef struct packed {
		sba_state_t                    state;
		logic [`SBA_NUM_MASTERS-1:0]   grant;
		logic [`SBA_IDX_W-1:0]         owner;
		logic [`SBA_IDX_W-1:0]         rr_ptr;
		logic                          boost_active;
	} sba_regs_t;

endpackage

`default_nettype wire

// ===== system_bus_arbiter_bench.sv
/*
 * Self-checking bench of the system bus arbiter with modelled masters.
 * Assumes the arbiter and the master model are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module system_bus_arbiter_bench;
	import sba_pkg::*;
	logic       ref_clk, rst_n, sel, boost_en, irq, clr, bus_busy, boost_act;
	logic [7:0] want, bus_req, bus_grant;
	logic [2:0] bus_owner;
	int         n_fail, cmp_count;

	sba_arbiter dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
		.priority_scheme_select(sel), .core_boost_enable(boost_en),
		.irq_pending(irq), .core_boost_active_clr(clr), .bus_grant(bus_grant),
		.bus_owner(bus_owner), .bus_busy(bus_busy), .core_boost_active(boost_act));
	sba_masters masters (.ref_clk(ref_clk), .rst_n(rst_n), .want(want),
		.hold(4'h2), .bus_grant(bus_grant), .bus_req(bus_req));

	// The clock toggles every half period of 4 ns.
	always #4 ref_clk = ~ref_clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Raises a set of requests at once and follows the grants in the given order,
	// checking that each grant is held alone until its owner releases and that one
	// idle cycle separates two owners. A stuck grant counts as a mismatch. Returns
	// on a rising edge so that callers drive their inputs there.
	task automatic serve(input logic [7:0] m, input logic [31:0] ord, input int n);
		int w;
		@(posedge ref_clk);
		want <= m;
		@(posedge ref_clk);
		want <= 8'h00;
		for (int k = 0; k < n; k++) begin
			w = 0;
			while (bus_busy !== 1'b1 && w < 50) begin
				@(negedge ref_clk);
				w++;
			end
			chk({7'h00, bus_busy}, 8'h01);
			if (k > 0) begin
				chk(8'(w), 8'h01);
			end
			chk({5'h00, bus_owner}, {5'h00, ord[4*k +: 3]});
			while (bus_busy === 1'b1 && w < 50) begin
				chk(bus_grant, 8'h01 << ord[4*k +: 3]);
				@(negedge ref_clk);
				w++;
			end
			chk({7'h00, bus_busy}, 8'h00);
		end
		@(posedge ref_clk);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Fixed order with the boost disabled, so a pending interrupt must not help the core.
	task automatic t_fixed;
		@(posedge ref_clk);
		sel      <= 1'b0;
		boost_en <= 1'b0;
		irq      <= 1'b1;
		serve(8'hFF, 32'h7654_3210, 8);
		@(negedge ref_clk);
		chk({7'h00, boost_act}, 8'h00);
	endtask

	// Boost flag set by an interrupt, kept against a clear in the same cycle and
	// after the interrupt goes, then cleared by a pulse. Outputs are read at the
	// falling edge, where the registered values have settled.
	task automatic t_boost;
		@(posedge ref_clk);
		boost_en <= 1'b1;
		irq      <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({7'h00, boost_act}, 8'h00);
		@(posedge ref_clk);
		irq <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({7'h00, boost_act}, 8'h01);
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		@(negedge ref_clk);
		chk({7'h00, boost_act}, 8'h01);
		serve(8'hFF, 32'h6543_2170, 8);
		irq <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({7'h00, boost_act}, 8'h01);
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		@(negedge ref_clk);
		chk({7'h00, boost_act}, 8'h00);
	endtask

	// Rotation ignores the boost and a pending interrupt, keeps the external master
	// first and moves on, also past a master that asks again right after its turn.
	task automatic t_rotate;
		@(posedge ref_clk);
		sel <= 1'b1;
		irq <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chk({7'h00, boost_act}, 8'h00);
		serve(8'h06, 32'h0000_0021, 2);
		serve(8'h8B, 32'h0000_1730, 4);
		serve(8'h12, 32'h0000_0014, 2);
	endtask

	// Main sequence: reset for eight cycles, then the scenarios in turn.
	initial begin
		ref_clk  = 1'b0;
		rst_n    = 1'b0;
		sel      = 1'b0;
		boost_en = 1'b0;
		irq      = 1'b0;
		clr      = 1'b0;
		want     = 8'h00;
		n_fail   = 0;
		cmp_count = 0;
		wait_cyc(8);
		rst_n <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(bus_grant, 8'h00);
		chk({7'h00, bus_busy}, 8'h00);
		t_fixed();
		t_boost();
		t_rotate();
		end_sim();
	end

	// A hang is cut short well after the expected run of about 160 cycles.
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
endmodule
`default_nettype wire
